//--- design/sapc_pkg.sv
// shared constants for the second audio port digital path control bank
package sapc_pkg;

  // ****************************************
  // port geometry
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // ****************************************
  // register offsets (word addresses)
  // ****************************************
  localparam logic [11:0] OFF_REC_LEFT = 12'h500;
  localparam logic [11:0] OFF_REC_RIGHT = 12'h501;
  localparam logic [11:0] OFF_PLAY_LEFT = 12'h502;
  localparam logic [11:0] OFF_PLAY_RIGHT = 12'h503;
  localparam logic [11:0] OFF_REC_FILTER = 12'h510;
  localparam logic [11:0] OFF_PLAY_MUTE = 12'h520;
  localparam logic [11:0] OFF_PLAY_WIDTH = 12'h521;
  localparam logic [11:0] OFF_GATE = 12'h530;
  localparam logic [11:0] OFF_DETECT = 12'h540;

  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_COMMIT = 8;
  localparam int POS_HPF_CORNER = 13;
  localparam int POS_HPF_LEFT = 12;
  localparam int POS_HPF_RIGHT = 11;
  localparam int POS_SOFT_MUTE = 9;
  localparam int POS_MONO = 7;
  localparam int POS_RAMP_SPEED = 5;
  localparam int POS_UNMUTE_RAMP = 4;
  localparam int POS_DEPTH = 9;
  localparam int POS_WIDTH_ON = 8;
  localparam int POS_HOLD = 5;
  localparam int POS_THRESHOLD = 1;
  localparam int POS_GATE_ON = 0;
  localparam int POS_DET_RMS = 11;
  localparam int POS_DET_CREST = 9;
  localparam int POS_DET_METHOD = 7;
  localparam int POS_DET_ON = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_GAIN = 8'hC0;
  localparam logic [1:0] RST_HPF_CORNER = 2'h0;
  localparam logic RST_SOFT_MUTE = 1'b1;
  localparam logic [4:0] RST_DEPTH = 5'h00;
  localparam logic [1:0] RST_HOLD = 2'h3;
  localparam logic [2:0] RST_THRESHOLD = 3'h4;
  localparam logic [4:0] RST_DET_RMS = 5'h00;
  localparam logic [1:0] RST_DET_CREST = 2'h0;
  localparam logic RST_DET_METHOD = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned HOLD0_MS = 30;
  localparam int unsigned HOLD1_MS = 125;
  localparam int unsigned HOLD2_MS = 250;
  localparam int unsigned HOLD3_MS = 500;
  localparam int unsigned HOLD0_CYC = HOLD0_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD1_CYC = HOLD1_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD2_CYC = HOLD2_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD3_CYC = HOLD3_MS * (CLK_HZ / 1000);
  localparam int GATE_CNT_W = 25;
  // soft mute ramp steps once per this many sample ticks
  localparam int unsigned RAMP_FAST_DIV = 2;
  localparam int unsigned RAMP_SLOW_DIV = 32;
  localparam logic [4:0] RAMP_FAST_LAST = 5'(RAMP_FAST_DIV - 1);
  localparam logic [4:0] RAMP_SLOW_LAST = 5'(RAMP_SLOW_DIV - 1);

endpackage

//--- design/sapc_path_ctrl.sv
// control register bank and gain sequencing for the second audio port paths
// Function
// - record volume commit applies left and right record gains together
// - playback volume commit applies left and right playback gains together
// - record gain code: 00h mute, 0.375dB steps to EFh, reset C0h
// - playback gain code: 00h mute, C0h up to FFh all 0dB
// - two-bit record highpass corner selector, hi-fi or three voice modes
// - separate left and right record highpass enables, reset off
// - soft mute bit mutes playback path, resets to muted
// - ramp speed bit picks step every 2 or every 32 samples
// - unmute jumps to volume when select zero, ramps when one
// - mono mix bit combines playback channels, reset off
// - five-bit stereo width depth code, zero means off
// - stereo widening runs only while its enable is set
// - gate hold time 30, 125, 250 or 500 ms before gate engages
// - three-bit gate threshold, -60dB to -102dB, reset code 100
// - noise gate works only while its enable is set
// - level method: detect against five-bit level threshold
// - crest method: detect against two-bit crest threshold
// - method bit: zero crest, one level, reset level
// - signal detection works only while its enable is set
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps

module sapc_path_ctrl #(
  parameter int unsigned HOLD0_CYC = sapc_pkg::HOLD0_CYC,
  parameter int unsigned HOLD1_CYC = sapc_pkg::HOLD1_CYC,
  parameter int unsigned HOLD2_CYC = sapc_pkg::HOLD2_CYC,
  parameter int unsigned HOLD3_CYC = sapc_pkg::HOLD3_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic fs_tick_i,
  input wire logic gate_quiet_i,
  input wire logic [4:0] det_level_meas_i,
  input wire logic [1:0] det_crest_meas_i,
  output logic [7:0] record_left_gain_o,
  output logic [7:0] record_right_gain_o,
  output logic [7:0] playback_left_gain_o,
  output logic [7:0] playback_right_gain_o,
  output logic playback_muted_o,
  output logic [1:0] record_highpass_corner_o,
  output logic record_left_highpass_on_o,
  output logic record_right_highpass_on_o,
  output logic playback_mono_mix_o,
  output logic [4:0] stereo_width_depth_o,
  output logic stereo_width_on_o,
  output logic [2:0] gate_threshold_o,
  output logic gate_active_o,
  output logic detect_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + 8'h01;
    end else if (cur > tgt) begin
      step_toward = cur - 8'h01;
    end else begin
      step_toward = cur;
    end
  endfunction
  function automatic logic [24:0] hold_last(input logic [1:0] code);
    unique case (code)
      2'h0: hold_last = 25'(HOLD0_CYC - 1);
      2'h1: hold_last = 25'(HOLD1_CYC - 1);
      2'h2: hold_last = 25'(HOLD2_CYC - 1);
      2'h3: hold_last = 25'(HOLD3_CYC - 1);
    endcase
  endfunction

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] rec_l_pend_reg;
  logic [7:0] rec_r_pend_reg;
  logic [7:0] play_l_pend_reg;
  logic [7:0] play_r_pend_reg;
  logic [7:0] play_l_act_reg;
  logic [7:0] play_r_act_reg;
  logic soft_mute_reg;
  logic ramp_speed_reg;
  logic unmute_ramp_reg;
  logic [1:0] hold_reg;
  logic gate_on_reg;
  logic [4:0] det_level_reg;
  logic [1:0] det_crest_reg;
  logic det_method_reg;
  logic det_on_reg;
  logic [4:0] ramp_cnt_reg;
  logic [24:0] gate_cnt_reg;

  // ****************************************
  // address decode
  // ****************************************
  wire logic wr_rec_l = wr_i && (addr_i == sapc_pkg::OFF_REC_LEFT);
  wire logic wr_rec_r = wr_i && (addr_i == sapc_pkg::OFF_REC_RIGHT);
  wire logic wr_play_l = wr_i && (addr_i == sapc_pkg::OFF_PLAY_LEFT);
  wire logic wr_play_r = wr_i && (addr_i == sapc_pkg::OFF_PLAY_RIGHT);
  wire logic wr_filter = wr_i && (addr_i == sapc_pkg::OFF_REC_FILTER);
  wire logic wr_mute = wr_i && (addr_i == sapc_pkg::OFF_PLAY_MUTE);
  wire logic wr_width = wr_i && (addr_i == sapc_pkg::OFF_PLAY_WIDTH);
  wire logic wr_gate = wr_i && (addr_i == sapc_pkg::OFF_GATE);
  wire logic wr_detect = wr_i && (addr_i == sapc_pkg::OFF_DETECT);
  wire logic commit_bit = wdata_i[sapc_pkg::POS_COMMIT];
  // the commit bit lives in both volume words of a pair
  wire logic rec_commit = (wr_rec_l || wr_rec_r) && commit_bit;
  wire logic play_commit = (wr_play_l || wr_play_r) && commit_bit;
  wire logic [7:0] rec_l_new = wr_rec_l ? wdata_i[7:0] : rec_l_pend_reg;
  wire logic [7:0] rec_r_new = wr_rec_r ? wdata_i[7:0] : rec_r_pend_reg;
  wire logic [7:0] play_l_new = wr_play_l ? wdata_i[7:0] : play_l_pend_reg;
  wire logic [7:0] play_r_new = wr_play_r ? wdata_i[7:0] : play_r_pend_reg;

  // ****************************************
  // read mux
  // ****************************************
  logic [15:0] rdata_next;
  always_comb begin
    rdata_next = 16'h0000;
    unique case (addr_i)
      sapc_pkg::OFF_REC_LEFT: rdata_next = {8'h00, rec_l_pend_reg};
      sapc_pkg::OFF_REC_RIGHT: rdata_next = {8'h00, rec_r_pend_reg};
      sapc_pkg::OFF_PLAY_LEFT: rdata_next = {8'h00, play_l_pend_reg};
      sapc_pkg::OFF_PLAY_RIGHT: rdata_next = {8'h00, play_r_pend_reg};
      sapc_pkg::OFF_REC_FILTER: begin
        rdata_next[sapc_pkg::POS_HPF_CORNER +: 2] = record_highpass_corner_o;
        rdata_next[sapc_pkg::POS_HPF_LEFT] = record_left_highpass_on_o;
        rdata_next[sapc_pkg::POS_HPF_RIGHT] = record_right_highpass_on_o;
      end
      sapc_pkg::OFF_PLAY_MUTE: begin
        rdata_next[sapc_pkg::POS_SOFT_MUTE] = soft_mute_reg;
        rdata_next[sapc_pkg::POS_MONO] = playback_mono_mix_o;
        rdata_next[sapc_pkg::POS_RAMP_SPEED] = ramp_speed_reg;
        rdata_next[sapc_pkg::POS_UNMUTE_RAMP] = unmute_ramp_reg;
      end
      sapc_pkg::OFF_PLAY_WIDTH: begin
        rdata_next[sapc_pkg::POS_DEPTH +: 5] = stereo_width_depth_o;
        rdata_next[sapc_pkg::POS_WIDTH_ON] = stereo_width_on_o;
      end
      sapc_pkg::OFF_GATE: begin
        rdata_next[sapc_pkg::POS_HOLD +: 2] = hold_reg;
        rdata_next[sapc_pkg::POS_THRESHOLD +: 3] = gate_threshold_o;
        rdata_next[sapc_pkg::POS_GATE_ON] = gate_on_reg;
      end
      sapc_pkg::OFF_DETECT: begin
        rdata_next[sapc_pkg::POS_DET_RMS +: 5] = det_level_reg;
        rdata_next[sapc_pkg::POS_DET_CREST +: 2] = det_crest_reg;
        rdata_next[sapc_pkg::POS_DET_METHOD] = det_method_reg;
        rdata_next[sapc_pkg::POS_DET_ON] = det_on_reg;
      end
      default: rdata_next = 16'h0000;
    endcase
  end

  // read data only stands in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rdata_next : 16'h0000;
    end
  end

  // ****************************************
  // volume words and commit
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rec_l_pend_reg <= sapc_pkg::RST_GAIN;
      rec_r_pend_reg <= sapc_pkg::RST_GAIN;
      play_l_pend_reg <= sapc_pkg::RST_GAIN;
      play_r_pend_reg <= sapc_pkg::RST_GAIN;
    end else if (ce_i) begin
      rec_l_pend_reg <= rec_l_new;
      rec_r_pend_reg <= rec_r_new;
      play_l_pend_reg <= play_l_new;
      play_r_pend_reg <= play_r_new;
    end
  end
  // the word written with the commit bit counts as part of the pair
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      record_left_gain_o <= sapc_pkg::RST_GAIN;
      record_right_gain_o <= sapc_pkg::RST_GAIN;
    end else if (ce_i && rec_commit) begin
      record_left_gain_o <= rec_l_new;
      record_right_gain_o <= rec_r_new;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      play_l_act_reg <= sapc_pkg::RST_GAIN;
      play_r_act_reg <= sapc_pkg::RST_GAIN;
    end else if (ce_i && play_commit) begin
      play_l_act_reg <= play_l_new;
      play_r_act_reg <= play_r_new;
    end
  end

  // ****************************************
  // filter, mute, width, gate, detect fields
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      record_highpass_corner_o <= sapc_pkg::RST_HPF_CORNER;
      record_left_highpass_on_o <= 1'b0;
      record_right_highpass_on_o <= 1'b0;
    end else if (ce_i && wr_filter) begin
      record_highpass_corner_o <= wdata_i[sapc_pkg::POS_HPF_CORNER +: 2];
      record_left_highpass_on_o <= wdata_i[sapc_pkg::POS_HPF_LEFT];
      record_right_highpass_on_o <= wdata_i[sapc_pkg::POS_HPF_RIGHT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      soft_mute_reg <= sapc_pkg::RST_SOFT_MUTE;
      playback_mono_mix_o <= 1'b0;
      ramp_speed_reg <= 1'b0;
      unmute_ramp_reg <= 1'b0;
    end else if (ce_i && wr_mute) begin
      soft_mute_reg <= wdata_i[sapc_pkg::POS_SOFT_MUTE];
      playback_mono_mix_o <= wdata_i[sapc_pkg::POS_MONO];
      ramp_speed_reg <= wdata_i[sapc_pkg::POS_RAMP_SPEED];
      unmute_ramp_reg <= wdata_i[sapc_pkg::POS_UNMUTE_RAMP];
    end
  end

  // depth is held even while widening is off
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      stereo_width_depth_o <= sapc_pkg::RST_DEPTH;
      stereo_width_on_o <= 1'b0;
    end else if (ce_i && wr_width) begin
      stereo_width_depth_o <= wdata_i[sapc_pkg::POS_DEPTH +: 5];
      stereo_width_on_o <= wdata_i[sapc_pkg::POS_WIDTH_ON];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hold_reg <= sapc_pkg::RST_HOLD;
      gate_threshold_o <= sapc_pkg::RST_THRESHOLD;
      gate_on_reg <= 1'b0;
    end else if (ce_i && wr_gate) begin
      hold_reg <= wdata_i[sapc_pkg::POS_HOLD +: 2];
      gate_threshold_o <= wdata_i[sapc_pkg::POS_THRESHOLD +: 3];
      gate_on_reg <= wdata_i[sapc_pkg::POS_GATE_ON];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      det_level_reg <= sapc_pkg::RST_DET_RMS;
      det_crest_reg <= sapc_pkg::RST_DET_CREST;
      det_method_reg <= sapc_pkg::RST_DET_METHOD;
      det_on_reg <= 1'b0;
    end else if (ce_i && wr_detect) begin
      det_level_reg <= wdata_i[sapc_pkg::POS_DET_RMS +: 5];
      det_crest_reg <= wdata_i[sapc_pkg::POS_DET_CREST +: 2];
      det_method_reg <= wdata_i[sapc_pkg::POS_DET_METHOD];
      det_on_reg <= wdata_i[sapc_pkg::POS_DET_ON];
    end
  end

  // ****************************************
  // soft mute ramp
  // ****************************************
  wire logic [4:0] ramp_last = ramp_speed_reg ? sapc_pkg::RAMP_SLOW_LAST
                                              : sapc_pkg::RAMP_FAST_LAST;
  wire logic ramp_tick = fs_tick_i && (ramp_cnt_reg >= ramp_last);
  wire logic [7:0] play_l_tgt = soft_mute_reg ? 8'h00 : play_l_act_reg;
  wire logic [7:0] play_r_tgt = soft_mute_reg ? 8'h00 : play_r_act_reg;
  // mute always ramps down; unmuted path follows volume at once unless ramp chosen
  wire logic jump_now = !soft_mute_reg && !unmute_ramp_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ramp_cnt_reg <= 5'h00;
    end else if (ce_i && fs_tick_i) begin
      ramp_cnt_reg <= ramp_tick ? 5'h00 : ramp_cnt_reg + 5'h01;
    end
  end

  // starts at zero: the path comes out of reset muted
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      playback_left_gain_o <= 8'h00;
      playback_right_gain_o <= 8'h00;
    end else if (ce_i) begin
      if (jump_now) begin
        playback_left_gain_o <= play_l_tgt;
        playback_right_gain_o <= play_r_tgt;
      end else if (ramp_tick) begin
        playback_left_gain_o <= step_toward(playback_left_gain_o, play_l_tgt);
        playback_right_gain_o <= step_toward(playback_right_gain_o, play_r_tgt);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      playback_muted_o <= 1'b1;
    end else if (ce_i) begin
      playback_muted_o <= soft_mute_reg;
    end
  end

  // ****************************************
  // noise gate hold
  // ****************************************
  wire logic gate_armed = gate_on_reg && gate_quiet_i;
  wire logic gate_due = gate_armed && (gate_cnt_reg >= hold_last(hold_reg));

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gate_cnt_reg <= 25'h0000000;
      gate_active_o <= 1'b0;
    end else if (ce_i) begin
      gate_cnt_reg <= gate_armed && !gate_due ? gate_cnt_reg + 25'h0000001 :
                      (gate_armed ? gate_cnt_reg : 25'h0000000);
      gate_active_o <= gate_due;
    end
  end

  // ****************************************
  // signal detect
  // ****************************************
  // smaller level code means louder; larger crest code means peakier
  wire logic level_hit = det_level_meas_i <= det_level_reg;
  wire logic crest_hit = det_crest_meas_i >= det_crest_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      detect_o <= 1'b0;
    end else if (ce_i) begin
      detect_o <= det_on_reg && (det_method_reg ? level_hit : crest_hit);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking chk_cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rec_commit;
    (ce_i && wr_rec_l && commit_bit) |=>
      (record_left_gain_o == $past(wdata_i[7:0])) &&
      (record_right_gain_o == $past(rec_r_pend_reg));
  endproperty
  a_rec_commit: assert property (p_rec_commit) else $error("record commit wrong");
  property p_play_commit;
    (ce_i && wr_play_r && commit_bit) |=>
      (play_r_act_reg == $past(wdata_i[7:0])) && (play_l_act_reg == $past(play_l_pend_reg));
  endproperty
  a_play_commit: assert property (p_play_commit) else $error("playback commit wrong");
  property p_pending_held;
    (ce_i && wr_rec_l && !commit_bit) |=> $stable(record_left_gain_o);
  endproperty
  a_pending_held: assert property (p_pending_held) else $error("gain moved early");
  property p_unmute_jump;
    (ce_i && !soft_mute_reg && !unmute_ramp_reg) |=> playback_left_gain_o == $past(play_l_act_reg);
  endproperty
  a_unmute_jump: assert property (p_unmute_jump) else $error("unmute not at once");
  property p_mute_step;
    (ce_i && ramp_tick && soft_mute_reg && playback_left_gain_o != 8'h00) |=>
      playback_left_gain_o == $past(playback_left_gain_o) - 8'h01;
  endproperty
  a_mute_step: assert property (p_mute_step) else $error("mute ramp step wrong");
  property p_no_tick_hold;
    (ce_i && !ramp_tick && soft_mute_reg) |=> $stable(playback_left_gain_o);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("gain moved off tick");
  property p_gate_off;
    (ce_i && !gate_on_reg) |=> !gate_active_o;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate active while off");
  property p_detect_off;
    (ce_i && !det_on_reg) |=> !detect_o;
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("detect while off");
  property p_detect_level;
    (ce_i && det_on_reg && det_method_reg) |=> detect_o == $past(level_hit);
  endproperty
  a_detect_level: assert property (p_detect_level) else $error("level detect wrong");
  property p_detect_crest;
    (ce_i && det_on_reg && !det_method_reg) |=> detect_o == $past(crest_hit);
  endproperty
  a_detect_crest: assert property (p_detect_crest) else $error("crest detect wrong");

endmodule // sapc_path_ctrl

//--- verification/sapc_audio_src.sv
// sample tick source standing in for the host on the audio port
`timescale 1ns/1ps
module sapc_audio_src #(
  parameter int DIV = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  output logic fs_tick_o
);
  logic [7:0] cnt_reg;
  // ****************************************
  // sample tick
  // ****************************************
  // locked to the system clock so ramp lengths stay exact
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || cnt_reg == 8'(DIV - 1)) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign fs_tick_o = rst_n_i && (cnt_reg == 8'(DIV - 1));
endmodule // sapc_audio_src

//--- verification/sapc_path_ctrl_tb_top.sv
// self-checking bench for the path control register bank
`timescale 1ns/1ps
module sapc_path_ctrl_tb_top;
  localparam int TICK = 4;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce = 1'b1;
  logic quiet = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic [1:0] crest = 2'h0;
  logic fs_tick, muted, mono, wid_on, lhp, rhp, gate_act, det_o;
  logic [15:0] rdata_o;
  logic [7:0] rl, rr, pl, pr;
  logic [1:0] corner;
  logic [4:0] depth;
  logic [2:0] thr;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  always #10 sys_clk_i = ~sys_clk_i;
  sapc_audio_src #(.DIV(TICK)) src (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .fs_tick_o(fs_tick));
  sapc_path_ctrl #(.HOLD0_CYC(4), .HOLD1_CYC(8), .HOLD2_CYC(12), .HOLD3_CYC(16)) uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fs_tick_i(fs_tick),
    .gate_quiet_i(quiet), .det_level_meas_i(lvl), .det_crest_meas_i(crest),
    .record_left_gain_o(rl), .record_right_gain_o(rr), .playback_left_gain_o(pl),
    .playback_right_gain_o(pr), .playback_muted_o(muted), .record_highpass_corner_o(corner),
    .record_left_highpass_on_o(lhp), .record_right_highpass_on_o(rhp),
    .playback_mono_mix_o(mono), .stereo_width_depth_o(depth), .stereo_width_on_o(wid_on),
    .gate_threshold_o(thr), .gate_active_o(gate_act), .detect_o(det_o));
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(rdata_o, exp);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic det(input logic [15:0] w, input logic [4:0] l, input logic [1:0] k,
                     input logic e);
    wr(12'h540, w);
    lvl <= l;
    crest <= k;
    settle(2);
    cmp({15'h0000, det_o}, {15'h0000, e});
  endtask
  // ****************************************
  // hang guard
  // ****************************************
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(12'h520, 16'h0200);
    rd(12'h530, 16'h0068);
    rd(12'h540, 16'h0080);
    rd(12'h500, 16'h00C0);
    rd(12'h510, 16'h0000);
    rd(12'h521, 16'h0000);
    rd(12'h5FF, 16'h0000);
    cmp({7'h00, muted, pl}, 16'h0100);
    wr(12'h501, 16'h0033);
    rd(12'h501, 16'h0033);
    cmp({rl, rr}, 16'hC0C0);
    wr(12'h500, 16'h0155);
    settle(1);
    cmp({rl, rr}, 16'h5533);
    wr(12'h503, 16'h0010);
    wr(12'h502, 16'h01C5);
    wr(12'h520, 16'h0000);
    settle(2);
    cmp({pl, pr}, 16'hC510);
    cmp({7'h00, muted, pl}, 16'h00C5);
    // fast mute ramp: one code per two samples
    wr(12'h520, 16'h0200);
    n = 0;
    while (pl !== 8'h00 && n < 4000) begin
      settle(1);
      n++;
    end
    cmp(16'(n > 194 * 2 * TICK && n < 200 * 2 * TICK), 16'h0001);
    cmp({pl, pr}, 16'h0000);
    // slow ramp on unmute
    wr(12'h503, 16'h0004);
    wr(12'h502, 16'h0102);
    wr(12'h520, 16'h0030);
    n = 0;
    while (pr !== 8'h04 && n < 2000) begin
      settle(1);
      n++;
    end
    cmp(16'(n > 3 * 32 * TICK && n < 5 * 32 * TICK + 8), 16'h0001);
    cmp({pl, pr}, 16'h0204);
    wr(12'h520, 16'h0080);
    settle(1);
    cmp({15'h0000, mono}, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(12'h510, 16'((c << 13) | (c[0] << 12) | (!c[0] << 11)));
      settle(1);
      cmp({12'h000, corner, lhp, rhp}, {12'h000, 2'(c), c[0], !c[0]});
    end
    wr(12'h521, 16'h3F00);
    settle(1);
    cmp({10'h000, depth, wid_on}, 16'h003F);
    wr(12'h521, 16'h0200);
    // clock enable low: the next write must not land
    ce <= 1'b0;
    settle(1);
    cmp({10'h000, depth, wid_on}, 16'h0002);
    wr(12'h521, 16'h0100);
    ce <= 1'b1;
    rd(12'h521, 16'h0200);
    for (int h = 0; h < 4; h++) begin
      wr(12'h530, 16'((h << 5) | ((7 - h) << 1) | 1));
      quiet <= 1'b1;
      n = 0;
      while (gate_act !== 1'b1 && n < 40) begin
        settle(1);
        n++;
      end
      cmp(16'(n >= 4 * (h + 1) - 1 && n <= 4 * (h + 1) + 2), 16'h0001);
      cmp({13'h0000, thr}, 16'(7 - h));
      @(posedge sys_clk_i);
      quiet <= 1'b0;
      settle(2);
    end
    wr(12'h530, 16'h0060);
    quiet <= 1'b1;
    settle(20);
    cmp({15'h0000, gate_act}, 16'h0000);
    @(posedge sys_clk_i);
    quiet <= 1'b0;
    det(16'h28C0, 5'h05, 2'h0, 1'b1);
    det(16'h28C0, 5'h06, 2'h0, 1'b0);
    det(16'h0440, 5'h1F, 2'h2, 1'b1);
    det(16'h0440, 5'h00, 2'h1, 1'b0);
    det(16'h0480, 5'h00, 2'h3, 1'b0);
    rd(12'h540, 16'h0480);
    results();
  end
endmodule // sapc_path_ctrl_tb_top
